// *** rtl/tscm_consts.vh ***
// Constants for the transmit status checksum merge block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
`ifndef TSCM_CONSTS_VH
`define TSCM_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSCM_OFS_CTRL      8'h00
`define TSCM_OFS_FLUSH    8'h04
`define TSCM_OFS_STATUS   8'h08
`define TSCM_OFS_IRQ_STS  8'h0c
`define TSCM_OFS_IRQ_MSK  8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSCM_CTRL_CSUM_EN  0
`define TSCM_CTRL_DROP     1
`define TSCM_IRQ_STS_DONE  0
`define TSCM_IRQ_FLUSH     1
`define TSCM_IRQ_OVF       2

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define TSCM_CTRL_RST      2'h1
`define TSCM_RESP_OKAY     2'h0
`define TSCM_RESP_SLVERR   2'h2

`endif

// *** rtl/tscm_top.v ***
// Transmit status path: checksum flag FIFO, status merge, flush statuses,
// and start-of-packet error binding towards the MAC transmitter.
// Assumes one clock, a well-behaved AXI4-Lite master and a MAC that
// returns one status per packet in hand-off order.
//
// How it works
// - Checksum flags returned with each transmit status
// - Push flags when packet handed to MAC
// - Pop flags on MAC status, return merged
// - Flush of other queue gives dummy statuses
// - Dummy flush status never pops flag FIFO
// - Software flush request bit per queue
// - Statuses returned only while drop control zero
// - SOP error affects only new packet
// - SOP error never reaches ongoing MAC frame
// - Bus error first beat becomes SOP error
`timescale 1ns/1ps
`default_nettype none
`include "tscm_consts.vh"

module tscm_top #(
   parameter NQ      = 4,
   parameter QW      = 2,
   parameter DEPTH   = 8,
   parameter AW      = 3,
   parameter DW      = 32
) (
   input  wire          sys_clk_i,
   input  wire          rst_i,
   // AXI4-Lite slave
   input  wire [7:0]    s_axi_awaddr_i,
   input  wire          s_axi_awvalid_i,
   output wire          s_axi_awready_o,
   input  wire [31:0]   s_axi_wdata_i,
   input  wire [3:0]    s_axi_wstrb_i,
   input  wire          s_axi_wvalid_i,
   output wire          s_axi_wready_o,
   output reg  [1:0]    s_axi_bresp_o,
   output reg           s_axi_bvalid_o,
   input  wire          s_axi_bready_i,
   input  wire [7:0]    s_axi_araddr_i,
   input  wire          s_axi_arvalid_i,
   output wire          s_axi_arready_o,
   output reg  [31:0]   s_axi_rdata_o,
   output reg  [1:0]    s_axi_rresp_o,
   output reg           s_axi_rvalid_o,
   input  wire          s_axi_rready_i,
   // Application side, one data beat per cycle
   input  wire          app_valid_i,
   output wire          app_ready_o,
   input  wire          app_sop_i,
   input  wire          app_eop_i,
   input  wire          app_err_i,
   input  wire          app_bus_err_i,
   input  wire [DW-1:0] app_data_i,
   input  wire [QW-1:0] app_queue_i,
   input  wire          app_ip_hdr_err_i,
   input  wire          app_pay_err_i,
   // MAC transmit side
   output reg           mac_valid_o,
   input  wire          mac_ready_i,
   output reg           mac_sop_o,
   output reg           mac_eop_o,
   output reg           mac_err_o,
   output reg  [DW-1:0] mac_data_o,
   input  wire          mac_sts_valid_i,
   input  wire [7:0]    mac_sts_i,
   input  wire          mac_busy_i,
   // Flushed packet count per flush, from the queue store
   input  wire [7:0]    flush_pkts_i,
   output reg  [QW-1:0] flush_q_o,
   output reg           flush_o,
   // Merged status to the application
   output reg           sts_valid_o,
   output reg  [7:0]    sts_mac_o,
   output reg           ip_header_error_flag_o,
   output reg           payload_csum_error_flag_o,
   output reg           sts_flush_o,
   output reg  [QW-1:0] sts_queue_o,
   output wire          irq_o
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [1:0]    ctrl_ff;
   reg  [NQ-1:0] queue_flush_req_ff;
   reg  [2:0]    irq_sts_ff;
   reg  [2:0]    irq_msk_ff;
   reg           aw_ff;
   reg  [7:0]    awaddr_ff;
   reg           w_ff;
   reg  [31:0]   wdata_ff;
   reg  [3:0]    wstrb_ff;

   wire tx_status_drop_ctl = ctrl_ff[`TSCM_CTRL_DROP];
   wire csum_en            = ctrl_ff[`TSCM_CTRL_CSUM_EN];

   // ----------------------------------------
   // Checksum flag FIFO
   // ----------------------------------------
   reg [2+QW-1:0] fifo_mem [0:DEPTH-1];
   reg [AW-1:0]   wr_ptr_ff;
   reg [AW-1:0]   rd_ptr_ff;
   reg [AW:0]     count_ff;
   reg [QW-1:0]   cur_q_ff;
   reg            in_pkt_ff;

   wire fifo_full  = (count_ff == DEPTH[AW:0]);
   wire fifo_empty = (count_ff == {(AW+1){1'b0}});

   // Stall new packets while the FIFO cannot hold another entry
   wire sop_block  = app_sop_i && fifo_full;
   assign app_ready_o = (mac_ready_i || !mac_valid_o) && !sop_block;
   wire beat       = app_valid_i && app_ready_o;
   wire push       = beat && app_sop_i;
   wire pop        = mac_sts_valid_i && !fifo_empty;

   // ----------------------------------------
   // Flush sequencer
   // ----------------------------------------
   localparam FL_IDLE = 2'd0;
   localparam FL_SEND = 2'd1;
   reg [1:0]    fl_state_ff;
   reg [7:0]    fl_cnt_ff;
   reg [QW-1:0] fl_q_ff;
   reg [QW-1:0] req_idx;
   reg          req_any;
   integer      i;

   always @* begin
      req_idx = {QW{1'b0}};
      req_any = 1'b0;
      for (i = NQ-1; i >= 0; i = i - 1) begin
         if (queue_flush_req_ff[i] &&
             !(in_pkt_ff && i[QW-1:0] == cur_q_ff)) begin
            req_any = 1'b1;
            req_idx = i[QW-1:0];
         end
      end
   end

   // Flush of the queue in transmission waits until its packet's last beat is taken
   wire fl_other = req_any;
   wire fl_start = (fl_state_ff == FL_IDLE) && fl_other;
   wire [NQ-1:0] fl_clr = fl_start ? ({{(NQ-1){1'b0}}, 1'b1} << req_idx)
                                   : {NQ{1'b0}};
   wire fl_emit  = (fl_state_ff == FL_SEND) && !pop && (fl_cnt_ff != 8'h00);

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   assign s_axi_awready_o = !aw_ff && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_ff && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   wire   wr_go = aw_ff && w_ff && !s_axi_bvalid_o;
   wire   wr_ok = (awaddr_ff <= `TSCM_OFS_IRQ_MSK) && (awaddr_ff[1:0] == 2'b00);

   function [31:0] rd_mux;
      input [7:0] a;
      begin
         case (a)
            `TSCM_OFS_CTRL:    rd_mux = {30'h0, ctrl_ff};
            `TSCM_OFS_FLUSH:   rd_mux = {{(32-NQ){1'b0}}, queue_flush_req_ff};
            `TSCM_OFS_STATUS:  rd_mux = {{(27-AW){1'b0}}, count_ff, 1'b0,
                                         fl_state_ff, in_pkt_ff};
            `TSCM_OFS_IRQ_STS: rd_mux = {29'h0, irq_sts_ff};
            `TSCM_OFS_IRQ_MSK: rd_mux = {29'h0, irq_msk_ff};
            default:           rd_mux = 32'h0;
         endcase
      end
   endfunction

   wire wr_ctrl  = wr_go && awaddr_ff == `TSCM_OFS_CTRL && wstrb_ff[0];
   wire wr_flush = wr_go && awaddr_ff == `TSCM_OFS_FLUSH && wstrb_ff[0];
   wire wr_isc   = wr_go && awaddr_ff == `TSCM_OFS_IRQ_STS && wstrb_ff[0];
   wire wr_msk   = wr_go && awaddr_ff == `TSCM_OFS_IRQ_MSK && wstrb_ff[0];
   wire rd_ok    = (s_axi_araddr_i <= `TSCM_OFS_IRQ_MSK) &&
                   (s_axi_araddr_i[1:0] == 2'b00);

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         aw_ff          <= 1'b0;
         w_ff           <= 1'b0;
         awaddr_ff      <= 8'h00;
         wdata_ff       <= 32'h0;
         wstrb_ff       <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `TSCM_RESP_OKAY;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rresp_o  <= `TSCM_RESP_OKAY;
         s_axi_rdata_o  <= 32'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_ff     <= 1'b1;
            awaddr_ff <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_ff     <= 1'b1;
            wdata_ff <= s_axi_wdata_i;
            wstrb_ff <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_ff          <= 1'b0;
            w_ff           <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? `TSCM_RESP_OKAY : `TSCM_RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux(s_axi_araddr_i);
            s_axi_rresp_o  <= rd_ok ? `TSCM_RESP_OKAY : `TSCM_RESP_SLVERR;
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Control, flush request and interrupt registers
   // ----------------------------------------
   wire [2:0] irq_ev = {app_valid_i && sop_block,
                        fl_emit,
                        pop};

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_ff            <= `TSCM_CTRL_RST;
         queue_flush_req_ff <= {NQ{1'b0}};
         irq_sts_ff         <= 3'h0;
         irq_msk_ff         <= 3'h0;
      end else begin
         if (wr_ctrl)
            ctrl_ff <= wdata_ff[1:0];
         if (wr_msk)
            irq_msk_ff <= wdata_ff[2:0];
         // Set wins over write-one-to-clear
         irq_sts_ff <= (irq_sts_ff & ~(wr_isc ? wdata_ff[2:0] : 3'h0))
                       | irq_ev;
         // Request stays set until the sequencer takes it
         // A write in the same cycle sets its bits again over the take
         queue_flush_req_ff <= (queue_flush_req_ff & ~fl_clr)
                               | (wr_flush ? wdata_ff[NQ-1:0]
                                           : {NQ{1'b0}});
      end
   end

   assign irq_o = |(irq_sts_ff & irq_msk_ff);

   // ----------------------------------------
   // Packet forwarding towards the MAC
   // ----------------------------------------
   // An error with SOP is held on the new SOP beat only, so the MAC
   // never sees it while finishing the previous frame's FCS.
   wire sop_err = app_sop_i && (app_err_i || app_bus_err_i);

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         mac_valid_o <= 1'b0;
         mac_sop_o   <= 1'b0;
         mac_eop_o   <= 1'b0;
         mac_err_o   <= 1'b0;
         mac_data_o  <= {DW{1'b0}};
         in_pkt_ff   <= 1'b0;
         cur_q_ff    <= {QW{1'b0}};
      end else begin
         if (app_ready_o) begin
            mac_valid_o <= app_valid_i;
            mac_sop_o   <= app_valid_i && app_sop_i;
            mac_eop_o   <= app_valid_i && app_eop_i;
            mac_data_o  <= app_data_i;
            // Error sampled with SOP is tied to that beat's packet
            mac_err_o   <= app_valid_i &&
                           (app_sop_i ? sop_err : app_err_i);
         end
         if (push) begin
            cur_q_ff  <= app_queue_i;
            in_pkt_ff <= !app_eop_i;
         end else if (beat && app_eop_i) begin
            in_pkt_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // FIFO and status merge
   // ----------------------------------------
   wire [1:0] push_flags = csum_en ? {app_ip_hdr_err_i, app_pay_err_i}
                                   : 2'b00;
   wire [2+QW-1:0] head = fifo_mem[rd_ptr_ff];

   always @(posedge sys_clk_i) begin
      if (push && !fifo_full)
         fifo_mem[wr_ptr_ff] <= {app_queue_i, push_flags};
   end

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ptr_ff   <= {AW{1'b0}};
         rd_ptr_ff   <= {AW{1'b0}};
         count_ff    <= {(AW+1){1'b0}};
         fl_state_ff <= FL_IDLE;
         fl_cnt_ff   <= 8'h00;
         fl_q_ff     <= {QW{1'b0}};
         flush_o     <= 1'b0;
         flush_q_o   <= {QW{1'b0}};
         sts_valid_o <= 1'b0;
         sts_mac_o   <= 8'h00;
         sts_flush_o <= 1'b0;
         sts_queue_o <= {QW{1'b0}};
         ip_header_error_flag_o    <= 1'b0;
         payload_csum_error_flag_o <= 1'b0;
      end else begin
         if (push && !fifo_full)
            wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         // Flush statuses leave the count alone
         count_ff <= count_ff + {{AW{1'b0}}, push && !fifo_full}
                              - {{AW{1'b0}}, pop};
         flush_o   <= fl_start;
         flush_q_o <= fl_start ? req_idx : flush_q_o;
         case (fl_state_ff)
            FL_IDLE: begin
               if (fl_start) begin
                  fl_state_ff <= FL_SEND;
                  fl_cnt_ff   <= flush_pkts_i;
                  fl_q_ff     <= req_idx;
               end
            end
            FL_SEND: begin
               if (fl_emit)
                  fl_cnt_ff <= fl_cnt_ff - 8'h01;
               else if (fl_cnt_ff == 8'h00)
                  fl_state_ff <= FL_IDLE;
            end
            default: fl_state_ff <= FL_IDLE;
         endcase
         // MAC status has priority; flush statuses fill idle cycles
         sts_valid_o <= !tx_status_drop_ctl && (pop || fl_emit);
         if (pop) begin
            sts_mac_o   <= mac_sts_i;
            sts_flush_o <= 1'b0;
            sts_queue_o <= head[2+QW-1:2];
            ip_header_error_flag_o    <= head[1];
            payload_csum_error_flag_o <= head[0];
         end else if (fl_emit) begin
            sts_mac_o   <= 8'h00;
            sts_flush_o <= 1'b1;
            sts_queue_o <= fl_q_ff;
            ip_header_error_flag_o    <= 1'b0;
            payload_csum_error_flag_o <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// *** testbench/tscm_properties.sv ***
// Checker for the transmit status merge block, bound to its top ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tscm_properties (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic app_valid_i,
   input wire logic app_ready_o,
   input wire logic app_sop_i,
   input wire logic app_err_i,
   input wire logic app_bus_err_i,
   input wire logic mac_valid_o,
   input wire logic mac_ready_i,
   input wire logic mac_sop_o,
   input wire logic mac_err_o,
   input wire logic mac_sts_valid_i,
   input wire logic flush_o,
   input wire logic sts_valid_o,
   input wire logic sts_flush_o,
   input wire logic ip_header_error_flag_o,
   input wire logic payload_csum_error_flag_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   logic fl;
   assign take = app_valid_i && app_ready_o;
   assign fl = sts_valid_o && sts_flush_o;
   chk_err_on_sop:
      assert property (take && app_sop_i && (app_err_i || app_bus_err_i)
         |=> mac_valid_o && mac_sop_o && mac_err_o)
      else $error("sop error not carried on its own beat");
   chk_clean_sop:
      assert property (take && app_sop_i && !app_err_i && !app_bus_err_i
         |=> !mac_err_o)
      else $error("error shown on a clean packet start");
   chk_beat_pass:
      assert property (take |=> mac_valid_o)
      else $error("accepted beat not forwarded");
   chk_beat_hold:
      assert property (mac_valid_o && !mac_ready_i |=> mac_valid_o
         && $stable(mac_sop_o) && $stable(mac_err_o))
      else $error("stalled beat changed");
   chk_merge_cause:
      assert property (sts_valid_o && !sts_flush_o |-> $past(mac_sts_valid_i))
      else $error("merged status without mac status");
   chk_flush_zero:
      assert property (fl |-> !ip_header_error_flag_o
         && !payload_csum_error_flag_o)
      else $error("flush status carries checksum flags");
   chk_flush_gap:
      assert property (fl |-> !$past(mac_sts_valid_i))
      else $error("flush status collided with mac status");
   chk_flush_pulse:
      assert property (flush_o |=> !flush_o)
      else $error("flush strobe longer than a cycle");
   cover property (take && app_sop_i && app_bus_err_i);
   cover property (fl);
   cover property (sts_valid_o && ip_header_error_flag_o);
endmodule
`default_nettype wire

// *** testbench/tscm_mac_model.sv ***
// MAC transmitter stand-in: random back-pressure, one status per packet.
// Assumes the bench seeds the random generator.
`timescale 1ns/1ps
`default_nettype none
module tscm_mac_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       mac_valid_i,
   input  wire logic       mac_eop_i,
   input  wire logic       hold_i,
   output var  logic       mac_ready_o,
   output var  logic       mac_sts_valid_o,
   output var  logic [7:0] mac_sts_o,
   output var  logic [7:0] seq_o
);
   int pend;
   always @(posedge clk_i) begin
      int done;
      if (rst_i) begin
         mac_ready_o <= 1'h0;
         mac_sts_valid_o <= 1'h0;
         mac_sts_o <= 8'h00;
         seq_o <= 8'h00;
         pend <= 0;
      end else begin
         done = mac_valid_i && mac_ready_o && mac_eop_i;
         mac_ready_o <= ($urandom % 4) != 0;
         // Statuses in hand-off order, numbered
         if (pend > 0 && !hold_i && ($urandom % 3) == 0) begin
            mac_sts_valid_o <= 1'h1;
            mac_sts_o <= seq_o;
            seq_o <= seq_o + 8'h01;
            pend <= pend - 1 + done;
         end else begin
            mac_sts_valid_o <= 1'h0;
            // Toggle so a stale read is caught
            mac_sts_o <= ~mac_sts_o;
            pend <= pend + done;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/test_tx_status_checksum_merge.sv ***
// Self-checking bench for the transmit status merge block.
// Assumes the checker and the MAC stand-in are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_tx_status_checksum_merge;
   logic        sys_clk_i = '0, rst_i = 1'h1, hold = '0, drop = '0;
   logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0, flush_pkts_i = 8'h03;
   logic [31:0] s_axi_wdata_i = '0, app_data_i = '0, rd, lastd;
   logic [3:0]  s_axi_wstrb_i = 4'hf;
   logic        s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
   logic        s_axi_arvalid_i = '0, s_axi_rready_i = '0, app_valid_i = '0;
   logic        app_sop_i = '0, app_eop_i = '0, app_err_i = '0, csum = 1'h1;
   logic        app_bus_err_i = '0, app_ip_hdr_err_i = '0, app_pay_err_i = '0;
   logic [1:0]  app_queue_i = '0, rr;
   logic        mac_busy_i = '0;
   logic [11:0] expq[$];
   int          errors = 0, checks_done = 0, seq = 0, nerr = 0, eseen = 0;
   int          nflush = 0;
   wire logic   s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, irq_o;
   wire logic   s_axi_arready_o, s_axi_rvalid_o, app_ready_o, mac_valid_o;
   wire logic   mac_ready_i, mac_sop_o, mac_eop_o, mac_err_o, mac_sts_valid_i;
   wire logic   flush_o, sts_valid_o, sts_flush_o;
   wire logic   ip_header_error_flag_o, payload_csum_error_flag_o;
   wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, sts_queue_o, fq;
   wire logic [31:0] s_axi_rdata_o, md;
   wire logic [7:0]  mac_sts_i, sts_mac_o, mseq;

   tscm_top DUT (.sys_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
      .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
      .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
      .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .app_valid_i,
      .app_ready_o, .app_sop_i, .app_eop_i, .app_err_i, .app_bus_err_i,
      .app_data_i, .app_queue_i, .app_ip_hdr_err_i, .app_pay_err_i,
      .mac_valid_o, .mac_ready_i, .mac_sop_o, .mac_eop_o, .mac_err_o,
      .mac_data_o(md), .mac_sts_valid_i, .mac_sts_i, .mac_busy_i,
      .flush_pkts_i, .flush_q_o(fq), .flush_o, .sts_valid_o, .sts_mac_o,
      .ip_header_error_flag_o, .payload_csum_error_flag_o, .sts_flush_o,
      .sts_queue_o, .irq_o);
   tscm_mac_model u_mac (.clk_i(sys_clk_i), .rst_i, .mac_valid_i(mac_valid_o),
      .mac_eop_i(mac_eop_o), .hold_i(hold), .mac_ready_o(mac_ready_i),
      .mac_sts_valid_o(mac_sts_valid_i), .mac_sts_o(mac_sts_i), .seq_o(mseq));

   always #25 sys_clk_i = ~sys_clk_i;

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tmo(input logic bad);
      if (bad) begin
         check("wait", 0, 1);
         wrap_up;
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'h1;
      s_axi_wvalid_i <= 1'h1;
      s_axi_bready_i <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
         if (s_axi_bvalid_o) break;
      end
      rr = s_axi_bresp_o;
      s_axi_bready_i <= 1'h0;
      tmo(!s_axi_bvalid_o);
   endtask
   task automatic axi_rd(input logic [7:0] a);
      int n;
      @(posedge sys_clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'h1;
      s_axi_rready_i <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
         if (s_axi_rvalid_o) break;
      end
      rd = s_axi_rdata_o;
      rr = s_axi_rresp_o;
      s_axi_rready_i <= 1'h0;
      tmo(!s_axi_rvalid_o);
   endtask
   task automatic send(input logic [1:0] q, input logic ih, pc, er, be,
                       input int len);
      int b, n;
      if (!drop) expq.push_back({8'(seq), ih & csum, pc & csum, q});
      seq++;
      if (er | be) nerr++;
      @(posedge sys_clk_i);
      for (b = 0; b < len; b++) begin
         app_valid_i <= 1'h1;
         app_sop_i <= (b == 0);
         app_eop_i <= (b == len - 1);
         app_err_i <= er && b == 0;
         app_bus_err_i <= be && b == 0;
         app_data_i <= $urandom;
         app_queue_i <= q;
         app_ip_hdr_err_i <= ih;
         app_pay_err_i <= pc;
         n = 0;
         do begin
            @(posedge sys_clk_i);
            n++;
         end while (!app_ready_o && n < 50);
         tmo(!app_ready_o);
      end
      app_valid_i <= 1'h0;
   endtask
   // Drain: every packet's status returned, every one not dropped shown
   task automatic idle;
      int n;
      for (n = 0; n < 300 && (mseq !== 8'(seq) || expq.size() > 0); n++)
         @(posedge sys_clk_i);
      repeat (2) @(posedge sys_clk_i);
      tmo(n == 300);
   endtask

   // -----------------------------------------------
   // Status scoreboard
   // -----------------------------------------------
   always @(posedge sys_clk_i) begin
      if (!rst_i && mac_valid_o && mac_ready_i && mac_err_o) eseen++;
      if (!rst_i && mac_valid_o === 1'h1)
         check("mac data", md, lastd);
      if (app_valid_i && app_ready_o) lastd <= app_data_i;
      if (!rst_i && flush_o === 1'h1) check("flush strobe q", fq, 2'h2);
      if (!rst_i && sts_valid_o === 1'h1) begin
         if (sts_flush_o) begin
            nflush++;
            check("flush flags", {sts_mac_o, ip_header_error_flag_o,
               payload_csum_error_flag_o}, 0);
            check("flush queue", sts_queue_o, 2'h2);
         end else if (expq.size() == 0) check("extra status", 1, 0);
         else check("merged", {sts_mac_o, ip_header_error_flag_o,
            payload_csum_error_flag_o, sts_queue_o}, expq.pop_front());
      end
   end

   initial begin
      void'($urandom(39));
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'h0;
      axi_rd(8'h00);
      check("ctrl reset", rd, 32'h1);
      axi_rd(8'h40);
      check("unmapped", {rr, rd}, {2'h2, 32'h0});
      axi_wr(8'h06, 32'h1);
      check("wr unaligned", rr, 2'h2);
      repeat (24) send(2'($urandom), 1'($urandom), 1'($urandom),
         ($urandom % 5) == 0, ($urandom % 5) == 1, 1 + $urandom % 4);
      send(2'h3, 1'h1, 1'h1, 1'h1, 1'h1, 1);
      hold <= 1'h1;
      send(2'h0, 1'h1, 1'h1, 1'h0, 1'h0, 2);
      axi_wr(8'h10, 32'h2);
      axi_wr(8'h04, 32'h4);
      check("wr resp", rr, 2'h0);
      for (int n = 0; n < 50 && nflush < 3; n++) @(posedge sys_clk_i);
      check("flush count", nflush, 3);
      check("irq flush", irq_o, 1'h1);
      axi_rd(8'h04);
      check("flush req", rd, 32'h0);
      hold <= 1'h0;
      idle;
      axi_wr(8'h0c, 32'h7);
      check("irq clear", irq_o, 1'h0);
      axi_wr(8'h10, 32'h0);
      axi_wr(8'h00, 32'h3);
      drop = 1'h1;
      repeat (3) send(2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2);
      idle;
      axi_wr(8'h00, 32'h0);
      drop = 1'h0;
      csum = 1'h0;
      send(2'h2, 1'h1, 1'h1, 1'h0, 1'h0, 3);
      idle;
      check("sop errors", eseen, nerr);
      check("pending", expq.size(), 0);
      wrap_up;
   end
endmodule
bind tscm_top tscm_properties u_chk (.sys_clk_i, .rst_i, .app_valid_i,
   .app_ready_o, .app_sop_i, .app_err_i, .app_bus_err_i, .mac_valid_o,
   .mac_ready_i, .mac_sop_o, .mac_err_o, .mac_sts_valid_i, .flush_o,
   .sts_valid_o, .sts_flush_o, .ip_header_error_flag_o,
   .payload_csum_error_flag_o);
`default_nettype wire
